// ===== inc/valve_io_regs.svh
// Constants of the valve sensor I/O and menu block: bit positions,
// reset values and timing counts. Assumes a 25 MHz device clock.
`ifndef VALVE_IO_REGS_SVH
`define VALVE_IO_REGS_SVH
`define CLK_HZ          25000000
`define ENTRY_HOLD_MS   3000
`define EXIT_HOLD_MS    3000
`define FLASH_MS        2000
`define IDLE_TIMEOUT_MS 30000
`define BLINK_MS        250
`define MS_CYCLES       (`CLK_HZ / 1000)
`define IN_POS_LSB      0
`define IN_FORCED       2
`define IN_CAL_FAIL     3
`define IN_EXT_SOL_REQ  4
`define IN_ALARM        5
`define OUT_SOL_CMD     0
`define OUT_SELF_CAL    2
`define OUT_FACT_RESET  4
`define ADDR_MAX        63
`define ADDR_RESET      6'h00
`define NUM_MODES       6
`endif

// ===== inc/valve_io_pkg.sv
// Types for the valve sensor I/O and menu block.
// Assumes no other package is needed.
package valve_io_pkg;
  typedef enum logic [3:0] {
    MENU_OFF     = 4'b0000,
    MENU_ENTRY   = 4'b0001,
    MENU_ALL     = 4'b0010,
    MENU_BROWSE  = 4'b0011,
    MENU_ONES    = 4'b0100,
    MENU_TENS    = 4'b0101,
    MENU_OPTION  = 4'b0110,
    MENU_CONFIRM = 4'b0111
  } menu_state_t;
  typedef enum logic [1:0] {
    POS_MID    = 2'b00,
    POS_CLOSED = 2'b01,
    POS_OPEN   = 2'b10
  } valve_pos_t;
endpackage : valve_io_pkg

// ===== logic/valve_sensor_io_and_menu.sv
// Valve sensor fieldbus I/O image and local magnetic-button menu.
// Assumes buttons are debounced and synchronous to mclk, and that
// position, calibration and alarm inputs come from the sensing core.
//
// Contract
// - Input bits 1:0 report position: 00 mid, 01 closed, 10 open.
// - Input bit 2 is set while the solenoid is forced locally.
// - Input bit 3 is one when self-calibration has failed.
// - Input bit 4 asks the master to power the external solenoid.
// - Rising edge of output bit 0 energises the solenoid.
// - Normally-open output option inverts position bits 1 and 0.
// - Remote parameters: calibrate request, calibration result, reset.
// - Node address accepted from 00 to 63 only.
// - Confirm held 3 s enters menu; ring flashes green 2 s.
// - After entry all flash, then mode 1; select steps six modes.
// - Select held over 3 s or 30 s idle leaves the menu.
// - Address item flashes LEDs 1 and 6; confirm opens ones digit.
// - Select steps ones digit 0 to 9; confirm moves to tens.
// - Select steps tens digit 0 to 6; confirm accepts address.
// - Solenoid option: red+green integrated, green external; 2 s flash.
// - Actuator type only with external solenoid: fail-closed or open.
// - With external solenoid, Alarm 1 enable choice is kept.
// - Output inversion swaps outputs 1 and 2; standard is red+green.
// - LED inversion: standard open green, inverted open red.
// - Alarm 1 flashes mode_led_1 red and clears with the fault.
`timescale 1ns/1ns
`include "valve_io_regs.svh"

module valve_sensor_io_and_menu #(
  parameter int ENTRY_CYC = `ENTRY_HOLD_MS * `MS_CYCLES,
  parameter int EXIT_CYC  = `EXIT_HOLD_MS * `MS_CYCLES,
  parameter int FLASH_CYC = `FLASH_MS * `MS_CYCLES,
  parameter int IDLE_CYC  = `IDLE_TIMEOUT_MS * `MS_CYCLES,
  parameter int BLINK_CYC = `BLINK_MS * `MS_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire valve_io_pkg::valve_pos_t raw_position,
  input  wire logic                   local_force,
  input  wire logic                   cal_failed,
  input  wire logic                   cal_ext_sol_req,
  input  wire logic                   alarm_unexpected,
  input  wire logic                   alarm_other,
  input  wire logic [7:0]             command_output_byte,
  input  wire logic [5:0]             remote_address,
  input  wire logic                   remote_address_we,
  input  wire logic                   select_button,
  input  wire logic                   confirm_button,
  output logic [7:0]                  status_input_byte,
  output logic                        solenoid_on,
  output logic                        self_cal_start,
  output logic                        cal_result_ok,
  output logic [5:0]                  node_address,
  output logic                        cfg_menu_active,
  output logic                        ext_solenoid,
  output logic                        fail_closed,
  output logic                        alarm1_enable,
  output logic                        output_invert,
  output logic                        led_invert,
  output logic [5:0]                  led_green,
  output logic [5:0]                  led_red
);
  import valve_io_pkg::*;

  if (ENTRY_CYC < 1 || EXIT_CYC < 1 || FLASH_CYC < 1 ||
      IDLE_CYC < 1 || BLINK_CYC < 1) begin : g_bad_timing
    $error("timing counts must be at least one cycle");
  end

  function automatic logic [3:0] wrap_inc(input logic [3:0] v,
                                          input logic [3:0] top);
    wrap_inc = (v >= top) ? 4'h0 : v + 4'h1;
  endfunction : wrap_inc

  //////////////////////////////////////////////////////////////////////
  // Remote command image
  logic [7:0]  cmd_q;
  menu_state_t state;
  menu_state_t next_state;
  logic [31:0] hold_cnt;
  logic [31:0] idle_cnt;
  logic [31:0] flash_cnt;
  logic [31:0] blink_cnt;
  logic        blink;
  logic        sel_q;
  logic        conf_q;
  logic [2:0]  mode;
  logic [2:0]  sub_item;
  logic        opt_pick;
  logic [3:0]  ones;
  logic [3:0]  tens;

  wire sol_rise   = command_output_byte[`OUT_SOL_CMD]
                    & ~cmd_q[`OUT_SOL_CMD];
  wire cal_rise   = command_output_byte[`OUT_SELF_CAL]
                    & ~cmd_q[`OUT_SELF_CAL];
  wire cal_fall   = ~command_output_byte[`OUT_SELF_CAL]
                    & cmd_q[`OUT_SELF_CAL];
  wire fact_reset = command_output_byte[`OUT_FACT_RESET];
  wire sol_fall   = ~command_output_byte[`OUT_SOL_CMD]
                    & cmd_q[`OUT_SOL_CMD];

  // Master must drop the self-cal bit at least 3 s after raising it
  logic        cal_armed;
  logic [31:0] cal_cnt;
  wire cal_go = cal_fall & cal_armed & (cal_cnt >= 32'(ENTRY_CYC));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_q          <= 8'h00;
      solenoid_on    <= 1'b0;
      cal_armed      <= 1'b0;
      cal_cnt        <= 32'h0000_0000;
      self_cal_start <= 1'b0;
      cal_result_ok  <= 1'b0;
    end else begin
      cmd_q <= command_output_byte;
      if (sol_rise)
        solenoid_on <= 1'b1;
      else if (sol_fall)
        solenoid_on <= 1'b0;
      if (cal_rise) begin
        cal_armed <= 1'b1;
        cal_cnt   <= 32'h0000_0000;
      end else if (cal_fall)
        cal_armed <= 1'b0;
      else if (cal_armed && cal_cnt != 32'hFFFF_FFFF)
        cal_cnt <= cal_cnt + 32'h0000_0001;
      self_cal_start <= cal_go;
      cal_result_ok  <= ~cal_failed;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Input image
  wire [1:0] pos_bits = output_invert ? ~raw_position : raw_position;
  wire [1:0] pos_img  = (raw_position == POS_MID) ? 2'b00 : pos_bits;

  always_ff @(posedge mclk) begin
    if (!rstn)
      status_input_byte <= 8'h00;
    else
      status_input_byte <= {2'b00,
                            alarm_unexpected | alarm_other,
                            ext_solenoid & cal_ext_sol_req,
                            cal_failed,
                            local_force,
                            pos_img};
  end

  //////////////////////////////////////////////////////////////////////
  // Menu timing
  wire sel_press  = select_button & ~sel_q;
  wire conf_press = confirm_button & ~conf_q;
  wire any_btn    = select_button | confirm_button;
  wire hold_done  = hold_cnt >= 32'(ENTRY_CYC);
  wire exit_hold  = select_button & (hold_cnt > 32'(EXIT_CYC));
  wire flash_done = flash_cnt >= 32'(FLASH_CYC);
  wire idle_out   = idle_cnt >= 32'(IDLE_CYC);
  wire in_menu    = state != MENU_OFF;
  wire leave      = in_menu && state != MENU_ENTRY &&
                    (exit_hold || idle_out);
  wire [3:0] next_ones = wrap_inc(ones, 4'd9);
  wire [3:0] next_tens = wrap_inc(tens, 4'd6);
  wire [6:0] addr_sum  = 7'(tens) * 7'd10 + 7'(ones);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sel_q     <= 1'b0;
      conf_q    <= 1'b0;
      hold_cnt  <= 32'h0000_0000;
      idle_cnt  <= 32'h0000_0000;
      blink_cnt <= 32'h0000_0000;
      blink     <= 1'b0;
    end else begin
      sel_q  <= select_button;
      conf_q <= confirm_button;
      if (any_btn && !(select_button && confirm_button))
        hold_cnt <= hold_cnt + 32'h0000_0001;
      else
        hold_cnt <= 32'h0000_0000;
      idle_cnt <= (any_btn || !in_menu) ? 32'h0000_0000
                                        : idle_cnt + 32'h0000_0001;
      if (blink_cnt >= 32'(BLINK_CYC - 1)) begin
        blink_cnt <= 32'h0000_0000;
        blink     <= ~blink;
      end else
        blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Menu state machine
  always_comb begin
    next_state = state;
    case (state)
      MENU_OFF:
        if (confirm_button && hold_done)
          next_state = MENU_ENTRY;
      MENU_ENTRY:
        if (flash_done)
          next_state = MENU_ALL;
      MENU_ALL:
        if (flash_done)
          next_state = MENU_BROWSE;
      MENU_BROWSE:
        if (conf_press && mode == 3'd1 && sub_item == 3'd0)
          next_state = MENU_ONES;
        else if (conf_press && (mode == 3'd2 || mode >= 3'd3))
          next_state = MENU_OPTION;
      MENU_ONES:
        if (conf_press)
          next_state = MENU_TENS;
      MENU_TENS:
        if (conf_press)
          next_state = MENU_CONFIRM;
      MENU_OPTION:
        if (conf_press)
          next_state = MENU_CONFIRM;
      MENU_CONFIRM:
        if (flash_done)
          next_state = MENU_BROWSE;
      default:
        next_state = MENU_OFF;
    endcase
    if (leave)
      next_state = MENU_OFF;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state     <= MENU_OFF;
      flash_cnt <= 32'h0000_0000;
    end else begin
      state     <= next_state;
      flash_cnt <= (next_state != state) ? 32'h0000_0000
                                         : flash_cnt + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Mode selection and settings
  // Mode 0..5 maps to mode_led_1..6. Under the solenoid item the
  // external choice opens two extra items: actuator type and Alarm 1.
  wire       sub_allowed = ext_solenoid && mode == 3'd2;
  wire [2:0] next_mode   = (mode == 3'(`NUM_MODES - 1)) ? 3'd0
                                                        : mode + 3'd1;

  always_ff @(posedge mclk) begin
    if (!rstn || fact_reset) begin
      mode          <= 3'd0;
      sub_item      <= 3'd0;
      opt_pick      <= 1'b0;
      ones          <= 4'h0;
      tens          <= 4'h0;
      node_address  <= `ADDR_RESET;
      ext_solenoid  <= 1'b0;
      fail_closed   <= 1'b1;
      alarm1_enable <= 1'b1;
      output_invert <= 1'b0;
      led_invert    <= 1'b0;
    end else begin
      if (state == MENU_ALL) begin
        mode     <= 3'd0;
        sub_item <= 3'd0;
      end
      if (state == MENU_BROWSE && sel_press) begin
        if (sub_allowed && sub_item < 3'd2)
          sub_item <= sub_item + 3'd1;
        else begin
          mode     <= next_mode;
          sub_item <= 3'd0;
        end
      end
      if (state == MENU_BROWSE && conf_press) begin
        ones     <= 4'(node_address % 6'd10);
        tens     <= 4'(node_address / 6'd10);
        opt_pick <= 1'b1;
      end
      if (state == MENU_ONES && sel_press)
        ones <= next_ones;
      if (state == MENU_TENS && sel_press)
        tens <= next_tens;
      if (state == MENU_TENS && conf_press && addr_sum <= 7'(`ADDR_MAX))
        node_address <= addr_sum[5:0];
      if (remote_address_we && remote_address <= 6'(`ADDR_MAX))
        node_address <= remote_address;
      if (state == MENU_OPTION && sel_press)
        opt_pick <= ~opt_pick;
      if (state == MENU_OPTION && conf_press) begin
        if (mode == 3'd2 && sub_item == 3'd0)
          ext_solenoid <= ~opt_pick;
        if (mode == 3'd2 && sub_item == 3'd1)
          fail_closed <= opt_pick;
        if (mode == 3'd2 && sub_item == 3'd2)
          alarm1_enable <= opt_pick;
        if (mode == 3'd3)
          output_invert <= ~opt_pick;
        if (mode == 3'd4)
          led_invert <= ~opt_pick;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // LED ring
  wire       pos_open   = raw_position == POS_OPEN;
  wire       pos_closed = raw_position == POS_CLOSED;
  wire       show_green = led_invert ? pos_closed : pos_open;
  wire       show_red   = led_invert ? pos_open : pos_closed;
  wire       alarm1     = alarm_unexpected & alarm1_enable;
  wire [5:0] mode_onehot = 6'b00_0001 << mode;
  wire [5:0] sel_leds   = (mode == 3'd1) ? 6'b10_0001 : mode_onehot;
  wire [5:0] flash_all  = blink ? 6'h3F : 6'h00;
  logic [5:0] next_green;
  logic [5:0] next_red;

  always_comb begin
    next_green = {6{show_green}};
    next_red   = {6{show_red}};
    case (state)
      MENU_ENTRY, MENU_CONFIRM: begin
        next_green = flash_all;
        next_red   = 6'h00;
      end
      MENU_ALL: begin
        next_green = flash_all;
        next_red   = flash_all;
      end
      MENU_BROWSE: begin
        next_green = blink ? sel_leds : 6'h00;
        next_red   = 6'h00;
      end
      MENU_ONES: begin
        next_green = blink ? 6'(ones) : 6'h00;
        next_red   = 6'h00;
      end
      MENU_TENS: begin
        next_green = blink ? 6'(tens) : 6'h00;
        next_red   = 6'h00;
      end
      MENU_OPTION: begin
        next_green = 6'b00_0100;
        next_red   = opt_pick ? 6'b00_0100 : 6'h00;
      end
      default: ;
    endcase
    if (state == MENU_OFF && alarm1)
      next_red[0] = blink;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      led_green       <= 6'h00;
      led_red         <= 6'h00;
      cfg_menu_active <= 1'b0;
    end else begin
      led_green       <= next_green;
      led_red         <= next_red;
      cfg_menu_active <= in_menu;
    end
  end

endmodule : valve_sensor_io_and_menu

// ===== sim/valve_io_asserts.sv
// Concurrent checks on the fieldbus image and settings outputs.
// Assumes a bind to valve_sensor_io_and_menu; it sees only its ports.
`timescale 1ns/1ns
module valve_io_asserts (
  input wire logic                     mclk,
  input wire logic                     rstn,
  input wire valve_io_pkg::valve_pos_t raw_position,
  input wire logic                     local_force,
  input wire logic                     cal_failed,
  input wire logic                     cal_ext_sol_req,
  input wire logic                     alarm_unexpected,
  input wire logic                     alarm_other,
  input wire logic [7:0]               command_output_byte,
  input wire logic [5:0]               remote_address,
  input wire logic                     remote_address_we,
  input wire logic [7:0]               status_input_byte,
  input wire logic                     solenoid_on,
  input wire logic                     cal_result_ok,
  input wire logic [5:0]               node_address,
  input wire logic                     ext_solenoid,
  input wire logic                     fail_closed,
  input wire logic                     alarm1_enable,
  input wire logic                     output_invert,
  input wire logic                     led_invert
);
  import valve_io_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////
  pos_report_a: assert property (
    !output_invert |=> status_input_byte[1:0] == $past(raw_position))
    else $error("position bits wrong");
  forced_bit_a: assert property (
    1 |=> status_input_byte[2] == $past(local_force))
    else $error("forced bit wrong");
  cal_fail_a: assert property (
    1 |=> status_input_byte[3] == $past(cal_failed))
    else $error("calibration fail bit wrong");
  ext_request_a: assert property (
    1 |=> status_input_byte[4] == $past(cal_ext_sol_req && ext_solenoid))
    else $error("solenoid request bit wrong");
  alarm_bits_a: assert property (
    1 |=> status_input_byte[7:6] == 2'h0 &&
          status_input_byte[5] == $past(alarm_unexpected | alarm_other))
    else $error("alarm or unused bits wrong");
  solenoid_rise_a: assert property (
    $rose(command_output_byte[0]) |=> solenoid_on)
    else $error("solenoid not energised");
  cal_result_a: assert property (
    1 |=> cal_result_ok != $past(cal_failed))
    else $error("calibration result wrong");
  remote_addr_a: assert property (
    remote_address_we |=> node_address == $past(remote_address))
    else $error("remote address not taken");
  factory_reset_a: assert property (
    command_output_byte[4] |=> fail_closed && alarm1_enable &&
      !ext_solenoid && !output_invert && !led_invert)
    else $error("factory defaults not restored");
endmodule : valve_io_asserts

bind valve_sensor_io_and_menu valve_io_asserts chk (
  .mclk, .rstn, .raw_position, .local_force, .cal_failed,
  .cal_ext_sol_req, .alarm_unexpected, .alarm_other,
  .command_output_byte, .remote_address, .remote_address_we,
  .status_input_byte, .solenoid_on, .cal_result_ok, .node_address,
  .ext_solenoid, .fail_closed, .alarm1_enable, .output_invert,
  .led_invert);

// ===== sim/fieldbus_master.sv
// Network master model: owns the one-byte output command image.
// Assumes the caller steps it from the mclk domain.
`timescale 1ns/1ns
module fieldbus_master (
  input  wire logic mclk,
  output logic [7:0] command_output_byte
);
  initial command_output_byte = 8'h00;
  //////////////////////////////////////////////////////////////////////////
  // Raise one command bit, hold it, then drop it; a long hold on bit 2
  // is what starts calibration, a short one must leave it void
  task automatic hold_bit(input int bitn, input int cycles);
    @(posedge mclk);
    command_output_byte[bitn] <= 1'b1;
    repeat (cycles) @(posedge mclk);
    command_output_byte[bitn] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : hold_bit
endmodule : fieldbus_master

// ===== sim/tb.sv
// Self-checking bench for the valve sensor I/O image and menu.
// Assumes shortened counts so the menu timing fits a short run.
`timescale 1ns/1ns
module tb;
  import valve_io_pkg::*;
  localparam int EC = 20;
  localparam int XC = 20;
  localparam int FC = 10;
  localparam int IC = 200;
  logic       mclk, rstn, local_force, cal_failed, cal_ext_sol_req;
  logic       alarm_unexpected, alarm_other, remote_address_we;
  logic       select_button, confirm_button, solenoid_on, self_cal_start;
  logic       cal_result_ok, cfg_menu_active, ext_solenoid, fail_closed;
  logic       alarm1_enable, output_invert, led_invert;
  logic [7:0] command_output_byte, status_input_byte;
  logic [5:0] remote_address, node_address, led_green, led_red;
  valve_pos_t raw_position;
  int         miscompares, total_checks, cal_pulses, sol_cycles;
  //////////////////////////////////////////////////////////////////////////
  valve_sensor_io_and_menu #(.ENTRY_CYC(EC), .EXIT_CYC(XC), .FLASH_CYC(FC),
    .IDLE_CYC(IC), .BLINK_CYC(2)) dut (.mclk, .rstn, .raw_position,
    .local_force, .cal_failed, .cal_ext_sol_req, .alarm_unexpected,
    .alarm_other, .command_output_byte, .remote_address,
    .remote_address_we, .select_button, .confirm_button,
    .status_input_byte, .solenoid_on, .self_cal_start, .cal_result_ok,
    .node_address, .cfg_menu_active, .ext_solenoid, .fail_closed,
    .alarm1_enable, .output_invert, .led_invert, .led_green, .led_red);
  fieldbus_master master (.mclk, .command_output_byte);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (self_cal_start === 1'b1) cal_pulses++;
  always @(posedge mclk) if (solenoid_on === 1'b1) sol_cycles++;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_n
  // A key touch; n sets how long the magnet is held over it
  task automatic press(input logic sel, input int n);
    @(posedge mclk);
    if (sel) select_button <= 1'b1;
    else confirm_button <= 1'b1;
    repeat (n) @(posedge mclk);
    select_button <= 1'b0;
    confirm_button <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : press
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////////
  task automatic t_status();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      raw_position <= valve_pos_t'(i);
      local_force <= (i == 0);
      cal_failed <= (i == 1);
      cal_ext_sol_req <= 1'b1;
      alarm_unexpected <= (i == 1);
      alarm_other <= (i == 2);
      wait_n(3);
      // Bit 4 stays low: the integrated solenoid is the default
      check("status", {2'h0, i != 0, 1'b0, i == 1, i == 0, 2'(i)},
            status_input_byte);
      check("cal_ok", 8'(i != 1), 8'(cal_result_ok));
      check("green", i == 2 ? 8'h3f : 8'h00, 8'(led_green));
      check("red", i == 1 ? 8'h1f : 8'h00, 8'(led_red[5:1]));
    end
    $display("t_status done");
  endtask : t_status
  task automatic t_command();
    master.hold_bit(0, 3);
    check("sol_on", 8'h03, 8'(sol_cycles));
    check("sol_off", 8'h00, 8'(solenoid_on));
    master.hold_bit(2, EC + 3);
    check("cal_long", 8'h01, 8'(cal_pulses));
    master.hold_bit(2, 5);
    check("cal_short", 8'h01, 8'(cal_pulses));
    $display("t_command done");
  endtask : t_command
  task automatic t_address();
    @(posedge mclk);
    remote_address <= 6'h3f;
    remote_address_we <= 1'b1;
    @(posedge mclk);
    remote_address_we <= 1'b0;
    wait_n(2);
    check("remote_addr", 8'h3f, 8'(node_address));
    press(1'b0, EC + 2);
    check("menu_on", 8'h01, 8'(cfg_menu_active));
    wait_n(2 * FC + 4);
    press(1'b1, 1);
    press(1'b0, 1);
    repeat (3) press(1'b1, 1);
    press(1'b0, 1);
    repeat (2) press(1'b1, 1);
    press(1'b0, 1);
    wait_n(FC + 2);
    // Digits open on the stored 63: ones 3 -> 6, tens 6 -> 0 -> 1
    check("menu_addr", 8'h10, 8'(node_address));
    press(1'b1, XC + 4);
    check("hold_exit", 8'h00, 8'(cfg_menu_active));
    press(1'b0, EC + 2);
    wait_n(IC + 4 * FC);
    check("idle_exit", 8'h00, 8'(cfg_menu_active));
    $display("t_address done");
  endtask : t_address
  // Step to an item, open it, flip the pick once and confirm it
  task automatic pick(input int steps);
    repeat (steps) press(1'b1, 1);
    press(1'b0, 1);
    press(1'b1, 1);
    press(1'b0, 1);
    wait_n(FC + 2);
  endtask : pick
  task automatic t_options();
    press(1'b0, EC + 2);
    wait_n(2 * FC + 4);
    pick(2);
    check("ext_sol", 8'h01, 8'(ext_solenoid));
    pick(1);
    check("fail_closed", 8'h00, 8'(fail_closed));
    pick(2);
    check("out_inv", 8'h01, 8'(output_invert));
    // Open now reads as closed; bit 4 follows the external solenoid
    check("status_inv", 8'h31, status_input_byte);
    press(1'b1, XC + 4);
    check("opt_exit", 8'h00, 8'(cfg_menu_active));
    $display("t_options done");
  endtask : t_options
  task automatic t_factory();
    master.hold_bit(4, 2);
    check("fact_addr", 8'h00, 8'(node_address));
    check("fact_fc", 8'h01, 8'(fail_closed));
    check("fact_ext", 8'h00, 8'(ext_solenoid));
    check("fact_inv", 8'h00, 8'(output_invert));
    $display("t_factory done");
  endtask : t_factory
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, local_force, cal_failed, cal_ext_sol_req} = 4'h0;
    {alarm_unexpected, alarm_other, remote_address_we} = 3'h0;
    {select_button, confirm_button} = 2'h0;
    raw_position = POS_MID;
    remote_address = 6'h00;
    {miscompares, total_checks, cal_pulses, sol_cycles} = {4{32'h0000_0000}};
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    wait_n(2);
    check("rst_alarm1", 8'h01, 8'(alarm1_enable));
    t_status();
    t_command();
    t_address();
    t_options();
    t_factory();
    conclude();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    conclude();
  end
endmodule : tb
